/* File: data_eeprom_pkg.sv */
// Constants for the data EEPROM access controller: register offsets,
// field positions, reset values, unlock key bytes and timing counts.
// Assumes a 25 MHz instruction clock and an 8-bit register space.
package data_eeprom_pkg;

	// Clock period in nanoseconds
	localparam int unsigned CLK_PERIOD_NS = 40;

	// Register offsets in the special register space
	localparam logic [7:0] OFS_PERIPHERAL_FLAG = 8'h0c;
	localparam logic [7:0] OFS_CELL_VALUE = 8'h9a;
	localparam logic [7:0] OFS_CELL_INDEX = 8'h9b;
	localparam logic [7:0] OFS_NV_CONTROL = 8'h9c;
	localparam logic [7:0] OFS_UNLOCK_KEY = 8'h9d;

	// Field positions in the control register
	localparam int unsigned CTL_FETCH_BIT = 0;
	localparam int unsigned CTL_LAUNCH_BIT = 1;
	localparam int unsigned CTL_PERMIT_BIT = 2;
	localparam int unsigned CTL_ABORT_BIT = 3;

	// Field position of the store done flag in the peripheral flag register
	localparam int unsigned PF_DONE_BIT = 7;

	// Reset values
	localparam logic [7:0] CELL_VALUE_RST = 8'h00;
	localparam logic [6:0] CELL_INDEX_RST = 7'h00;

	// Array geometry
	localparam int unsigned ARRAY_ADDR_W = 7;
	localparam int unsigned ARRAY_DEPTH = 128;

	// Unlock key bytes, in the order they must arrive
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Exact spacing in cycles: first key to second key, second key to launch
	localparam logic [1:0] KEY_GAP_FIRST = 2'h2;
	localparam logic [1:0] KEY_GAP_LAUNCH = 2'h1;

	// Counter width for the long timers
	localparam int unsigned TIMER_W = 24;

	// Power-up delay in milliseconds, and in cycles
	localparam int unsigned POWERUP_TIME_MS = 72;
	localparam int unsigned POWERUP_CYCLES = (POWERUP_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// Array programming time in microseconds, and in cycles
	localparam int unsigned WRITE_TIME_US = 5000;
	localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

	// Unlock sequence tracker states
	typedef enum logic [2:0] {
		KEY_IDLE = 3'b001,
		KEY_GOT_FIRST = 3'b010,
		KEY_ARMED = 3'b100
	} unlock_state_e;

endpackage

/* File: data_eeprom_ctrl.sv */
// Data EEPROM access controller: indirect register access to a 128-byte
// array, unlock key checking, timed byte writes and reset abort tracking.
// Assumes the CPU core drives the register port synchronously to mclk and
// that reset cause levels are valid while reset_n is held low.
//
// Contract
// - Write cut by reset sets abort flag; the code sets it only on master clear, brown-out or an awake watchdog
// - Permit bit zero refuses write start
// - Launch bit only set by software
// - Fetch bit self clears after one cycle
// - Fetched byte ready on the next cycle
// - Cell value holds until read or write
// - Key 55h, then AAh, then launch
// - Wrong unlock cycle count suppresses write
// - Hardware never clears the permit bit; the code clears it on every reset
// - Clearing permit leaves running write alone
// - Launch needs permit already set
// - Completion clears launch, sets done flag
// - Done flag sticky until software clears
// - Power-up clears the permit bit
// - No writes while power-up timer runs
// - Lock bit zero protects the array
// - CPU access unaffected by protection
// - 128 bytes, index top bit ignored
// - Timed erase then write per byte; the code runs one timed write with no erase step
// - Unlock key port reads all zeros
// - Aborting reset clears index and value
`timescale 1ns/10ps

module data_eeprom_ctrl
	import data_eeprom_pkg::*;
#(
	parameter int unsigned POWERUP_DELAY = data_eeprom_pkg::POWERUP_CYCLES,
	parameter int unsigned WRITE_DELAY = data_eeprom_pkg::WRITE_CYCLES
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Reset cause levels, valid while reset_n is low
	input wire logic por_cause,
	input wire logic master_clear_pin,
	input wire logic watchdog_timer,
	input wire logic cpu_sleeping,
	input wire logic brownout_detect,
	// Configuration
	input wire logic powerup_delay_timer_n,
	input wire logic data_readout_lock,
	// Register port
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	// Device programmer read port
	input wire logic [6:0] prog_addr,
	output logic [7:0] prog_rdata,
	// Status
	output logic store_done_flag,
	output logic write_busy
);

	import data_eeprom_pkg::*;

	// Last counts of the timers: each parameter minus one, narrowed to the timer width
	localparam logic [TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST = TIMER_W'(POWERUP_DELAY - 1);
	localparam logic [TIMER_W-1:0] WRITE_LAST = TIMER_W'(WRITE_DELAY - 1);

	// Decode helper for a strobe at one offset
	function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
		hit = stb && (a == ofs);
	endfunction

	// Storage array, never reset so contents survive any reset
	logic [7:0] array_mem [ARRAY_DEPTH];

	// Software-visible registers
	logic [7:0] cell_value_r;
	logic [6:0] cell_index_r;
	logic program_abort_flag_r;
	logic program_permit_bit_r;
	logic launch_r;
	logic fetch_r;
	logic store_done_r;

	// Write engine state
	logic [TIMER_W-1:0] write_cnt_r;
	logic [6:0] wr_index_r;
	logic [7:0] wr_value_r;

	// Power-up delay state
	logic [TIMER_W-1:0] powerup_delay_timer_cnt_r;
	logic powerup_delay_timer_busy_r;
	logic powerup_delay_timer_start_r;

	// Unlock tracker
	unlock_state_e key_state_r;
	logic [1:0] key_cnt_r;

	// Read data and programmer data registers
	logic [7:0] bus_rdata_r;
	logic [7:0] prog_rdata_r;

	// Decoded strobes
	logic wr_value;
	logic wr_index;
	logic wr_ctl;
	logic wr_key;
	logic wr_pf;
	logic fetch_start;
	logic launch_req;
	logic launch_start;
	logic write_done;
	logic abort_cause;

	assign wr_value = hit(bus_wr, bus_addr, OFS_CELL_VALUE);
	assign wr_index = hit(bus_wr, bus_addr, OFS_CELL_INDEX);
	assign wr_ctl = hit(bus_wr, bus_addr, OFS_NV_CONTROL);
	assign wr_key = hit(bus_wr, bus_addr, OFS_UNLOCK_KEY);
	assign wr_pf = hit(bus_wr, bus_addr, OFS_PERIPHERAL_FLAG);

	// Read start: software can only set the fetch bit
	assign fetch_start = wr_ctl && bus_wdata[CTL_FETCH_BIT];

	// Launch request seen on the control port
	assign launch_req = wr_ctl && bus_wdata[CTL_LAUNCH_BIT];

	// Launch only with permit already set, armed key at the exact count,
	// power-up delay finished and no write already running
	assign launch_start = launch_req && !launch_r
		&& program_permit_bit_r
		&& (key_state_r == KEY_ARMED)
		&& (key_cnt_r == KEY_GAP_LAUNCH - 2'h1)
		&& !powerup_delay_timer_busy_r;

	// End of the timed programming interval
	assign write_done = launch_r && (write_cnt_r == WRITE_LAST);

	// Resets that cut a write short; a watchdog reset counts only when awake
	assign abort_cause = master_clear_pin || brownout_detect
		|| (watchdog_timer && !cpu_sleeping);

	// Unlock tracker: each step must land on its exact cycle or it is lost
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			key_state_r <= KEY_IDLE;
			key_cnt_r <= 2'h0;
		end
		else
		begin
			// Saturating cycle count since the last key event
			if (key_cnt_r != 2'h3)
				key_cnt_r <= key_cnt_r + 2'h1;
			case (key_state_r)
				KEY_IDLE:
				begin
					if (wr_key && bus_wdata == KEY_FIRST)
					begin
						key_state_r <= KEY_GOT_FIRST;
						key_cnt_r <= 2'h0;
					end
				end
				KEY_GOT_FIRST:
				begin
					// Second key only on the exact cycle
					if (wr_key && bus_wdata == KEY_SECOND
						&& key_cnt_r == KEY_GAP_FIRST - 2'h1)
					begin
						key_state_r <= KEY_ARMED;
						key_cnt_r <= 2'h0;
					end
					else if (wr_key && bus_wdata == KEY_FIRST)
					begin
						key_cnt_r <= 2'h0;
					end
					else if (wr_key || key_cnt_r >= KEY_GAP_FIRST - 2'h1)
					begin
						key_state_r <= KEY_IDLE;
					end
				end
				KEY_ARMED:
				begin
					// Armed for one exact cycle; any outcome disarms it
					if (wr_key && bus_wdata == KEY_FIRST)
					begin
						key_state_r <= KEY_GOT_FIRST;
						key_cnt_r <= 2'h0;
					end
					else if (launch_req || wr_key || key_cnt_r >= KEY_GAP_LAUNCH - 2'h1)
					begin
						key_state_r <= KEY_IDLE;
					end
				end
				default:
				begin
					key_state_r <= KEY_IDLE;
				end
			endcase
		end
	end

	// Power-up delay: starts once after a power-on reset releases
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			// Catch the power-on cause while reset is held
			powerup_delay_timer_start_r <= por_cause && !powerup_delay_timer_n;
			powerup_delay_timer_busy_r <= 1'b0;
			powerup_delay_timer_cnt_r <= '0;
		end
		else if (powerup_delay_timer_start_r)
		begin
			powerup_delay_timer_start_r <= 1'b0;
			powerup_delay_timer_busy_r <= 1'b1;
			powerup_delay_timer_cnt_r <= '0;
		end
		else if (powerup_delay_timer_busy_r)
		begin
			// Writes stay blocked until the full delay has run
			if (powerup_delay_timer_cnt_r == POWERUP_DELAY_TIMER_LAST)
				powerup_delay_timer_busy_r <= 1'b0;
			powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + TIMER_W'(1);
		end
	end

	// Abort flag: set by a master clear, brown-out or awake watchdog reset that lands on a running write
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			// Power-on clears it; other resets keep it or set it
			if (por_cause)
				program_abort_flag_r <= 1'b0;
			else if (launch_r && abort_cause)
				program_abort_flag_r <= 1'b1;
		end
		else if (wr_ctl)
		begin
			program_abort_flag_r <= bus_wdata[CTL_ABORT_BIT];
		end
	end

	// Permit bit: software alone changes it, every reset clears it
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			program_permit_bit_r <= 1'b0;
		else if (wr_ctl)
			program_permit_bit_r <= bus_wdata[CTL_PERMIT_BIT];
	end

	// Launch bit and write timer; permit changes do not touch a running write
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			launch_r <= 1'b0;
			write_cnt_r <= '0;
			wr_index_r <= CELL_INDEX_RST;
			wr_value_r <= CELL_VALUE_RST;
		end
		else if (launch_start)
		begin
			// Latch the target so later register writes cannot disturb it
			launch_r <= 1'b1;
			write_cnt_r <= '0;
			wr_index_r <= cell_index_r;
			wr_value_r <= cell_value_r;
		end
		else if (write_done)
		begin
			launch_r <= 1'b0;
		end
		else if (launch_r)
		begin
			write_cnt_r <= write_cnt_r + TIMER_W'(1);
		end
	end

	// Array programming: the byte is replaced whole, so no separate erase
	always_ff @(posedge mclk)
	begin
		if (reset_n && write_done)
			array_mem[wr_index_r] <= wr_value_r;
	end

	// Fetch bit: set by software, cleared by hardware one cycle later
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			fetch_r <= 1'b0;
		else
			fetch_r <= fetch_start;
	end

	// Cell value: fetched byte or software data, cleared by any reset
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			cell_value_r <= CELL_VALUE_RST;
		else if (fetch_start)
			cell_value_r <= array_mem[cell_index_r];
		else if (wr_value)
			cell_value_r <= bus_wdata;
	end

	// Cell index: top bit is dropped, only 128 locations exist
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			cell_index_r <= CELL_INDEX_RST;
		else if (wr_index)
			cell_index_r <= bus_wdata[ARRAY_ADDR_W-1:0];
	end

	// Store done flag: completion wins over a same-cycle software clear
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			store_done_r <= 1'b0;
		else if (write_done)
			store_done_r <= 1'b1;
		else if (wr_pf)
			store_done_r <= bus_wdata[PF_DONE_BIT];
	end

	// Register read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			bus_rdata_r <= 8'h00;
		else if (bus_rd)
		begin
			case (bus_addr)
				OFS_PERIPHERAL_FLAG: bus_rdata_r <= {store_done_r, 7'h00};
				OFS_CELL_VALUE: bus_rdata_r <= cell_value_r;
				OFS_CELL_INDEX: bus_rdata_r <= {1'b0, cell_index_r};
				OFS_NV_CONTROL: bus_rdata_r <= {4'h0, program_abort_flag_r,
					program_permit_bit_r, launch_r, fetch_r};
				// Key port has no storage behind it
				OFS_UNLOCK_KEY: bus_rdata_r <= 8'h00;
				default: bus_rdata_r <= 8'h00;
			endcase
		end
		else
		begin
			bus_rdata_r <= 8'h00;
		end
	end

	// Programmer read: blanked while the readout lock is programmed to zero
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			prog_rdata_r <= 8'h00;
		else if (!data_readout_lock)
			prog_rdata_r <= 8'h00;
		else
			prog_rdata_r <= array_mem[prog_addr];
	end

	assign bus_rdata = bus_rdata_r;
	assign prog_rdata = prog_rdata_r;
	assign store_done_flag = store_done_r;
	assign write_busy = launch_r;

	// Checks on the block's own behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// Fetch bit never stays high two cycles running
	fetch_pulse_a: assert property (fetch_r |=> !fetch_r)
		else $error("fetch bit stayed set");

	// Fetched byte matches the array the cycle after the start
	fetch_data_a: assert property (fetch_start |=> cell_value_r == array_mem[cell_index_r])
		else $error("fetched byte wrong");

	// Cell value holds without a fetch or software write
	value_hold_a: assert property (!fetch_start && !wr_value |=> $stable(cell_value_r))
		else $error("cell value changed on its own");

	// Launch only rises with permit already set
	launch_permit_a: assert property ($rose(launch_r) |-> $past(program_permit_bit_r))
		else $error("launch without permit");

	// Launch only rises after the full key sequence
	launch_key_a: assert property ($rose(launch_r) |-> $past(key_state_r == KEY_ARMED))
		else $error("launch without unlock");

	// Permit stays set unless software writes the control register
	permit_hold_a: assert property (program_permit_bit_r && !wr_ctl |=> program_permit_bit_r)
		else $error("permit cleared by hardware");

	// Running write survives any control write until its timer ends
	launch_stick_a: assert property (launch_r && !write_done |=> launch_r)
		else $error("write cut short");

	// Launch falls only with the done flag rising; a drop caused by reset is excused
	finish_done_a: assert property ($fell(launch_r) && $past(reset_n) |-> store_done_r)
		else $error("done flag missing");

	// Done flag clears only through a software write
	done_sticky_a: assert property (store_done_r && !wr_pf |=> store_done_r)
		else $error("done flag cleared by hardware");

	// Key port reads as zero
	key_read_a: assert property (hit(bus_rd, bus_addr, OFS_UNLOCK_KEY) |=> bus_rdata == 8'h00)
		else $error("key port read nonzero");

	// No launch while the power-up delay runs
	powerup_delay_timer_block_a: assert property (powerup_delay_timer_busy_r |=> !$rose(launch_r))
		else $error("write during power-up delay");

endmodule

/* File: cpu_bus_model.sv */
// CPU-side master model for the controller's register port.
// Assumes the slave never stalls and that read data follow one cycle later.
`timescale 1ns/10ps

module cpu_bus_model
(
	// Clock
	input wire logic mclk,
	// Register port
	output logic [7:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd
);
	import data_eeprom_pkg::*;

	// Quiet bus at time zero
	initial
	begin
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end

	// One write strobe; the next call or an idle drops it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		bus_rd <= 1'b0;
	endtask

	// One read strobe; data appear in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		bus_addr <= a;
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
	endtask

	// Released bus: address and data toggle so stale values never look valid
	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			bus_wr <= 1'b0;
			bus_rd <= 1'b0;
			bus_addr <= ~bus_addr;
			bus_wdata <= ~bus_wdata;
		end
	endtask

	// Full byte store: location and byte first, then keys with exact spacing.
	// No interrupt source exists in this model, so the sequence is never split.
	task automatic unlock_write(input logic [7:0] idx, input logic [7:0] val,
		input logic [7:0] ctl);
		wr(OFS_CELL_INDEX, idx);
		wr(OFS_CELL_VALUE, val);
		wr(OFS_NV_CONTROL, 8'h04);
		wr(OFS_UNLOCK_KEY, KEY_FIRST);
		idle(1);
		wr(OFS_UNLOCK_KEY, KEY_SECOND);
		wr(OFS_NV_CONTROL, ctl);
	endtask
endmodule

/* File: test_data_eeprom_ctrl.sv */
// Self-checking bench for the data EEPROM access controller.
// Assumes short power-up and write delays set through the parameters.
`timescale 1ns/10ps

module test_data_eeprom_ctrl;
	import data_eeprom_pkg::*;

	// Write time in cycles for simulation; the real one is far too long to run
	localparam int WR_CYCLES = 8;
	// Design signals
	logic mclk = 1'b0;
	logic reset_n;
	logic por_cause, master_clear_pin, watchdog_timer, cpu_sleeping;
	logic brownout_detect, powerup_delay_timer_n, data_readout_lock;
	logic [6:0] prog_addr;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, prog_rdata;
	logic bus_wr, bus_rd, store_done_flag, write_busy;
	// Bench state
	logic [7:0] exp_q[$];
	logic rd_d = 1'b0;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	logic [31:0] seed = 32'h05c4;
	logic [7:0] idx, val;

	always #20 mclk = ~mclk;

	data_eeprom_ctrl #(.POWERUP_DELAY(16), .WRITE_DELAY(WR_CYCLES)) data_eeprom_ctrl_inst (
		.mclk(mclk), .reset_n(reset_n), .por_cause(por_cause),
		.master_clear_pin(master_clear_pin), .watchdog_timer(watchdog_timer),
		.cpu_sleeping(cpu_sleeping), .brownout_detect(brownout_detect),
		.powerup_delay_timer_n(powerup_delay_timer_n),
		.data_readout_lock(data_readout_lock), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
		.store_done_flag(store_done_flag), .write_busy(write_busy));

	cpu_bus_model cpu_bus_model_inst (
		.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd));

	// Single comparison point
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Read with its expected answer noted for the monitor
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cpu_bus_model_inst.rd(a);
	endtask

	// Reset low for two edges with the given cause levels; the levels then
	// stay put, since the design looks at them only while reset is low
	task automatic pulse_reset(input logic [5:0] cause);
		cpu_bus_model_inst.idle(1);
		{por_cause, master_clear_pin, watchdog_timer, cpu_sleeping, brownout_detect,
			powerup_delay_timer_n} <= cause;
		reset_n <= 1'b0;
		cpu_bus_model_inst.idle(2);
		reset_n <= 1'b1;
	endtask

	// Store cut short by a reset of the given causes, then what it leaves behind
	task automatic cut_store(input logic [5:0] cause, input logic [7:0] exp_ctl);
		cpu_bus_model_inst.unlock_write(idx, ~val, 8'h06);
		cpu_bus_model_inst.idle(1);
		pulse_reset(cause);
		check("busy after cut", {7'h00, write_busy}, 8'h00);
		rd_exp(OFS_NV_CONTROL, exp_ctl);
		rd_exp(OFS_CELL_VALUE, 8'h00);
		rd_exp(OFS_CELL_INDEX, 8'h00);
	endtask

	// Closing report, the only exit
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Monitor: read data count only in the cycle after the strobe
	always @(posedge mclk)
	begin
		if (rd_d && exp_q.size() > 0)
			check("read data", bus_rdata, exp_q.pop_front());
		rd_d <= bus_rd;
	end

	// Hang guard, far above the fewer than two hundred cycles the sequence needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	initial
	begin
		// Power-on reset with the power-up delay enabled
		reset_n <= 1'b0;
		{por_cause, master_clear_pin, watchdog_timer, cpu_sleeping, brownout_detect,
			powerup_delay_timer_n} <= 6'h20;
		data_readout_lock <= 1'b1;
		prog_addr <= 7'h00;
		idx = 8'($random(seed));
		val = 8'($random(seed));
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		// Reset values, key port and a hole in the map
		rd_exp(OFS_CELL_VALUE, 8'h00);
		rd_exp(OFS_CELL_INDEX, 8'h00);
		rd_exp(OFS_NV_CONTROL, 8'h00);
		rd_exp(OFS_PERIPHERAL_FLAG, 8'h00);
		rd_exp(OFS_UNLOCK_KEY, 8'h00);
		rd_exp(8'h50, 8'h00);
		// Launch while the power-up delay runs is refused
		cpu_bus_model_inst.unlock_write(idx, val, 8'h06);
		rd_exp(OFS_NV_CONTROL, 8'h04);
		cpu_bus_model_inst.idle(20);
		// Keys one cycle apart: sequence broken
		cpu_bus_model_inst.wr(OFS_UNLOCK_KEY, KEY_FIRST);
		cpu_bus_model_inst.wr(OFS_UNLOCK_KEY, KEY_SECOND);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h06);
		rd_exp(OFS_NV_CONTROL, 8'h04);
		// Permit clear: launch cannot set
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h00);
		cpu_bus_model_inst.wr(OFS_UNLOCK_KEY, KEY_FIRST);
		cpu_bus_model_inst.idle(1);
		cpu_bus_model_inst.wr(OFS_UNLOCK_KEY, KEY_SECOND);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h02);
		rd_exp(OFS_NV_CONTROL, 8'h00);
		// Good store to an index with the top bit set
		cpu_bus_model_inst.unlock_write({1'b1, idx[6:0]}, val, 8'h06);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h04);
		rd_exp(OFS_NV_CONTROL, 8'h06);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h00);
		rd_exp(OFS_NV_CONTROL, 8'h02);
		cpu_bus_model_inst.idle(1);
		@(negedge mclk);
		check("busy", {7'h00, write_busy}, 8'h01);
		for (n = 0; n < 40 && write_busy !== 1'b0; n++)
			cpu_bus_model_inst.idle(1);
		cpu_bus_model_inst.idle(3);
		rd_exp(OFS_PERIPHERAL_FLAG, 8'h80);
		rd_exp(OFS_NV_CONTROL, 8'h00);
		rd_exp(OFS_CELL_INDEX, {1'b0, idx[6:0]});
		cpu_bus_model_inst.wr(OFS_PERIPHERAL_FLAG, 8'h00);
		rd_exp(OFS_PERIPHERAL_FLAG, 8'h00);
		// Fetch back over a different holding value
		cpu_bus_model_inst.wr(OFS_CELL_VALUE, ~val);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h01);
		rd_exp(OFS_CELL_VALUE, val);
		rd_exp(OFS_NV_CONTROL, 8'h00);
		cpu_bus_model_inst.idle(3);
		rd_exp(OFS_CELL_VALUE, val);
		// Programmer port open, then locked
		prog_addr <= idx[6:0];
		cpu_bus_model_inst.idle(2);
		check("prog open", prog_rdata, val);
		data_readout_lock <= 1'b0;
		cpu_bus_model_inst.idle(2);
		check("prog locked", prog_rdata, 8'h00);
		// Stores cut by master clear, awake watchdog, sleeping watchdog, brown-out
		cut_store(6'h10, 8'h08);
		cut_store(6'h08, 8'h08);
		cut_store(6'h0c, 8'h00);
		cut_store(6'h02, 8'h08);
		// Power-on reset with the delay disabled clears permit and abort
		pulse_reset(6'h21);
		rd_exp(OFS_NV_CONTROL, 8'h00);
		// None of the cut stores landed: the cell still holds the first byte
		cpu_bus_model_inst.wr(OFS_CELL_INDEX, idx);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h01);
		rd_exp(OFS_CELL_VALUE, val);
		// Refresh the same cell with new data while the readout lock is programmed to zero;
		// no power-up delay this time, and the write lasts exactly WR_CYCLES
		val = 8'($random(seed));
		cpu_bus_model_inst.unlock_write(idx, val, 8'h06);
		cpu_bus_model_inst.idle(1);
		@(negedge mclk);
		for (n = 0; n < 40 && write_busy !== 1'b0; n++)
			@(negedge mclk);
		check("write cycles", 8'(n), 8'(WR_CYCLES));
		check("done flag", {7'h00, store_done_flag}, 8'h01);
		cpu_bus_model_inst.wr(OFS_CELL_VALUE, ~val);
		cpu_bus_model_inst.wr(OFS_NV_CONTROL, 8'h01);
		rd_exp(OFS_CELL_VALUE, val);
		cpu_bus_model_inst.idle(3);
		tally_and_finish();
	end
endmodule
